// ==== hdl/bst_pkg.sv ====
// shared constants, types and decode for the boundary-scan test port
package bst_pkg;

    // instruction register
    localparam int IR_W = 10;
    localparam logic [9:0] IR_EXTEST = 10'h000;
    localparam logic [9:0] IR_SAMPLE = 10'h005;
    localparam logic [9:0] IR_BYPASS = 10'h3ff;
    localparam logic [9:0] IR_CONFIG = 10'h002;
    localparam logic [9:0] IR_CAPTURE = 10'h001;

    // boundary cell layout, one cell per pad, lsb nearest the scan output
    localparam int STD_W = 2;
    localparam logic [1:0] STD_RST = 2'h0;
    localparam int CELL_IN = 0;
    localparam int CELL_OUT = 1;
    localparam int CELL_OE = 2;
    localparam int CELL_STD = 3;
    localparam int CELL_W = 3 + STD_W;

    // update word layout per pad, as carried to the core clock
    localparam int UPD_OUT = 0;
    localparam int UPD_OE = 1;
    localparam int UPD_STD = 2;
    localparam int UPD_W = 2 + STD_W;

    // configuration bytes
    localparam int CFG_W = 8;
    localparam int CFG_CNT_W = 3;
    localparam logic [2:0] CFG_CNT_LAST = 3'h7;

    // tap controller states
    typedef enum logic [15:0] {
        ST_TLR = 16'h0001, ST_RTI = 16'h0002, ST_SEL_DR = 16'h0004, ST_CAP_DR = 16'h0008,
        ST_SH_DR = 16'h0010, ST_EX1_DR = 16'h0020, ST_PAU_DR = 16'h0040, ST_EX2_DR = 16'h0080,
        ST_UPD_DR = 16'h0100, ST_SEL_IR = 16'h0200, ST_CAP_IR = 16'h0400, ST_SH_IR = 16'h0800,
        ST_EX1_IR = 16'h1000, ST_PAU_IR = 16'h2000, ST_EX2_IR = 16'h4000, ST_UPD_IR = 16'h8000
    } bst_tap_t;

    // data register selected by the current instruction
    typedef enum logic [2:0] {
        PATH_BSR = 3'h1,
        PATH_BYP = 3'h2,
        PATH_CFG = 3'h4
    } bst_path_t;

    // unknown codes fall to bypass so the chain always stays one bit long
    function automatic bst_path_t bst_decode(input logic [IR_W-1:0] ir);
        bst_path_t p;
        case (ir)
            IR_EXTEST, IR_SAMPLE: p = PATH_BSR;
            IR_CONFIG: p = PATH_CFG;
            default: p = PATH_BYP;
        endcase
        return p;
    endfunction : bst_decode

endpackage : bst_pkg

// ==== hdl/bst_port.sv ====
// boundary-scan test port: tap, instruction and data registers, pad control
`timescale 1ns/1ps
`default_nettype none
// Function
// - tap and boundary chain follow the standard state machine on tck and tms.
// - a configuration instruction shifts bytes from the scan input to the core.
// - each pad's io standard field in the chain updates before or in user mode.
// - code 00 0000 0101 samples pins and preloads the boundary pattern.
// - code 00 0000 0000 drives pins from the chain and captures inputs.
// - code 11 1111 1111 puts one bypass bit between scan input and output.
module bst_port
    import bst_pkg::*;
#(
    parameter int PADS = 4
) (
    // core clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // scan link
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    // core logic side of the pads
    input wire logic [PADS-1:0] core_out,
    input wire logic [PADS-1:0] core_oe,
    output logic [PADS-1:0] core_in,
    // pad side
    input wire logic [PADS-1:0] pad_in,
    output logic [PADS-1:0] pad_out,
    output logic [PADS-1:0] pad_oe,
    output logic [PADS*STD_W-1:0] pad_iostd,
    // configuration bytes
    output logic [CFG_W-1:0] cfg_data,
    output logic cfg_valid
);

    localparam int BSR_W = PADS * CELL_W;
    localparam int UW = PADS * UPD_W;

    // reset value of the update word: pads released, default standard
    function automatic logic [UW-1:0] upd_reset();
        logic [UW-1:0] u;
        u = '0;
        for (int i = 0; i < PADS; i++) begin
            u[i*UPD_W+UPD_STD +: STD_W] = STD_RST;
        end
        return u;
    endfunction : upd_reset

    localparam logic [UW-1:0] UPD_RST = upd_reset();

    bst_tap_if tap();

    // link-domain reset, carried over from the core reset
    logic trst_s1_reg;
    logic trst_s2_reg;
    logic tap_rst;

    // pin and core levels brought into the link domain
    logic [PADS-1:0] tin_s1_reg;
    logic [PADS-1:0] tin_s2_reg;
    logic [PADS-1:0] tout_s1_reg;
    logic [PADS-1:0] tout_s2_reg;
    logic [PADS-1:0] toe_s1_reg;
    logic [PADS-1:0] toe_s2_reg;

    // scan registers
    logic [IR_W-1:0] ir_sr_reg;
    logic [IR_W-1:0] ir_sr_next;
    logic [IR_W-1:0] ir_reg;
    logic [IR_W-1:0] ir_next;
    logic [BSR_W-1:0] bsr_reg;
    logic [BSR_W-1:0] bsr_next;
    logic [UW-1:0] upd_reg;
    logic [UW-1:0] upd_next;
    logic byp_reg;
    logic byp_next;
    logic [CFG_W-1:0] cfg_sr_reg;
    logic [CFG_W-1:0] cfg_sr_next;
    logic [CFG_CNT_W-1:0] cfg_cnt_reg;
    logic [CFG_CNT_W-1:0] cfg_cnt_next;
    logic ext_reg;
    logic ext_next;
    logic cfg_load;
    logic upd_load;
    bst_path_t path;

    // falling-edge output stage
    logic tdo_next;
    logic tdo_oe_next;

    // core-domain state
    logic [PADS-1:0] cin_s1_reg;
    logic [PADS-1:0] cin_s2_reg;
    logic ext_s1_reg;
    logic ext_s2_reg;
    logic [UW-1:0] upd_core;
    logic [PADS-1:0] pad_out_next;
    logic [PADS-1:0] pad_oe_next;
    logic [PADS*STD_W-1:0] pad_iostd_next;

    assign tap.tms = tms;

    bst_tap_fsm u_fsm (
        .tck(tck),
        .tap_rst(tap_rst),
        .tap(tap)
    );

    // two-stage synchronisers into the link domain
    always_ff @(posedge tck) begin
        trst_s1_reg <= sys_rst;
        trst_s2_reg <= trst_s1_reg;
        tin_s1_reg <= pad_in;
        tin_s2_reg <= tin_s1_reg;
        tout_s1_reg <= pad_out;
        tout_s2_reg <= tout_s1_reg;
        toe_s1_reg <= pad_oe;
        toe_s2_reg <= toe_s1_reg;
    end

    assign tap_rst = trst_s2_reg;

    assign path = bst_decode(ir_reg);

    // next values of every link-domain scan register
    always_comb begin
        ir_sr_next = ir_sr_reg;
        ir_next = ir_reg;
        bsr_next = bsr_reg;
        upd_next = upd_reg;
        byp_next = byp_reg;
        cfg_sr_next = cfg_sr_reg;
        cfg_cnt_next = cfg_cnt_reg;
        cfg_load = 1'h0;
        upd_load = 1'h0;
        // instruction register path
        if (tap.tlr) begin
            ir_next = IR_BYPASS;
        end
        if (tap.cap_ir) begin
            ir_sr_next = IR_CAPTURE;
        end
        if (tap.sh_ir) begin
            ir_sr_next = {tdi, ir_sr_reg[IR_W-1:1]};
        end
        if (tap.upd_ir) begin
            ir_next = ir_sr_reg;
        end
        case (path)
            PATH_BSR: begin
                if (tap.cap_dr) begin
                    // output and enable cells capture what the pad is driven with
                    for (int i = 0; i < PADS; i++) begin
                        bsr_next[i*CELL_W+CELL_IN] = tin_s2_reg[i];
                        bsr_next[i*CELL_W+CELL_OUT] = tout_s2_reg[i];
                        bsr_next[i*CELL_W+CELL_OE] = toe_s2_reg[i];
                        bsr_next[i*CELL_W+CELL_STD +: STD_W] =
                            upd_reg[i*UPD_W+UPD_STD +: STD_W];
                    end
                end
                if (tap.sh_dr) begin
                    bsr_next = {tdi, bsr_reg[BSR_W-1:1]};
                end
                if (tap.upd_dr) begin
                    // preload in sample mode; pins follow only under extest
                    for (int i = 0; i < PADS; i++) begin
                        upd_next[i*UPD_W+UPD_OUT] = bsr_reg[i*CELL_W+CELL_OUT];
                        upd_next[i*UPD_W+UPD_OE] = bsr_reg[i*CELL_W+CELL_OE];
                        upd_next[i*UPD_W+UPD_STD +: STD_W] =
                            bsr_reg[i*CELL_W+CELL_STD +: STD_W];
                    end
                    upd_load = 1'h1;
                end
            end
            PATH_CFG: begin
                // byte alignment restarts at every capture
                if (tap.cap_dr) begin
                    cfg_cnt_next = '0;
                end
                if (tap.sh_dr) begin
                    cfg_sr_next = {tdi, cfg_sr_reg[CFG_W-1:1]};
                    cfg_cnt_next = cfg_cnt_reg + 3'h1;
                    cfg_load = (cfg_cnt_reg == CFG_CNT_LAST);
                end
            end
            default: begin
                // bypass, also reached by every undefined code
                if (tap.cap_dr) begin
                    byp_next = 1'h0;
                end
                if (tap.sh_dr) begin
                    byp_next = tdi;
                end
            end
        endcase
        // follows the incoming instruction, since tck may stop right after update-ir
        ext_next = (ir_next == IR_EXTEST);
    end

    // link-domain registers
    always_ff @(posedge tck) begin
        if (tap_rst) begin
            ir_sr_reg <= IR_CAPTURE;
            ir_reg <= IR_BYPASS;
            bsr_reg <= '0;
            upd_reg <= UPD_RST;
            byp_reg <= 1'h0;
            cfg_sr_reg <= '0;
            cfg_cnt_reg <= '0;
            ext_reg <= 1'h0;
        end else begin
            ir_sr_reg <= ir_sr_next;
            ir_reg <= ir_next;
            bsr_reg <= bsr_next;
            upd_reg <= upd_next;
            byp_reg <= byp_next;
            cfg_sr_reg <= cfg_sr_next;
            cfg_cnt_reg <= cfg_cnt_next;
            ext_reg <= ext_next;
        end
    end

    // scan output: selected register lsb, enabled only while shifting
    always_comb begin
        tdo_oe_next = tap.sh_ir | tap.sh_dr;
        if (tap.sh_ir) begin
            tdo_next = ir_sr_reg[0];
        end else begin
            case (path)
                PATH_BSR: tdo_next = bsr_reg[0];
                PATH_CFG: tdo_next = cfg_sr_reg[0];
                default: tdo_next = byp_reg;
            endcase
        end
    end

    // falling edge gives the tester half a period of setup
    always_ff @(negedge tck) begin
        if (tap_rst) begin
            tdo <= 1'h0;
            tdo_oe <= 1'h0;
        end else begin
            tdo <= tdo_next;
            tdo_oe <= tdo_oe_next;
        end
    end

    // boundary update word into the core clock
    bst_xfer #(
        .W(UW),
        .RST_VAL(UPD_RST)
    ) u_upd_xfer (
        .src_clk(tck),
        .src_rst(tap_rst),
        .src_load(upd_load),
        .src_data(upd_next),
        .dst_clk(core_clk),
        .dst_rst(sys_rst),
        .dst_data(upd_core),
        .dst_pulse()
    );

    // configuration bytes into the core clock; the tester must keep scans
    // and configuration apart, since this path shares the same pins
    bst_xfer #(
        .W(CFG_W),
        .RST_VAL(8'h00)
    ) u_cfg_xfer (
        .src_clk(tck),
        .src_rst(tap_rst),
        .src_load(cfg_load),
        .src_data(cfg_sr_next),
        .dst_clk(core_clk),
        .dst_rst(sys_rst),
        .dst_data(cfg_data),
        .dst_pulse(cfg_valid)
    );

    // two-stage synchronisers into the core domain
    always_ff @(posedge core_clk) begin
        cin_s1_reg <= pad_in;
        cin_s2_reg <= cin_s1_reg;
        ext_s1_reg <= ext_reg;
        ext_s2_reg <= ext_s1_reg;
    end

    // pad drive: core logic normally, the update word under extest
    always_comb begin
        for (int i = 0; i < PADS; i++) begin
            pad_out_next[i] = ext_s2_reg ? upd_core[i*UPD_W+UPD_OUT] : core_out[i];
            pad_oe_next[i] = ext_s2_reg ? upd_core[i*UPD_W+UPD_OE] : core_oe[i];
            pad_iostd_next[i*STD_W +: STD_W] = upd_core[i*UPD_W+UPD_STD +: STD_W];
        end
    end

    // core-domain pad registers
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pad_out <= '0;
            pad_oe <= '0;
            pad_iostd <= {PADS{STD_RST}};
            core_in <= '0;
        end else begin
            pad_out <= pad_out_next;
            pad_oe <= pad_oe_next;
            pad_iostd <= pad_iostd_next;
            core_in <= cin_s2_reg; // normal operation keeps running in sample
        end
    end

endmodule : bst_port
`default_nettype wire

// ==== hdl/bst_tap_fsm.sv ====
// sixteen-state tap controller stepped by the link clock and the mode select
`timescale 1ns/1ps
`default_nettype none
module bst_tap_fsm
    import bst_pkg::*;
(
    // link clock and its reset
    input wire logic tck,
    input wire logic tap_rst,
    // state and strobes
    bst_tap_if.fsm tap
);

    bst_tap_t state_reg;
    bst_tap_t state_next;

    // standard transition graph on the mode select
    always_comb begin
        case (state_reg)
            ST_TLR: state_next = tap.tms ? ST_TLR : ST_RTI;
            ST_RTI: state_next = tap.tms ? ST_SEL_DR : ST_RTI;
            ST_SEL_DR: state_next = tap.tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: state_next = tap.tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: state_next = tap.tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: state_next = tap.tms ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR: state_next = tap.tms ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR: state_next = tap.tms ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: state_next = tap.tms ? ST_SEL_DR : ST_RTI;
            ST_SEL_IR: state_next = tap.tms ? ST_TLR : ST_CAP_IR;
            ST_CAP_IR: state_next = tap.tms ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR: state_next = tap.tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: state_next = tap.tms ? ST_UPD_IR : ST_PAU_IR;
            ST_PAU_IR: state_next = tap.tms ? ST_EX2_IR : ST_PAU_IR;
            ST_EX2_IR: state_next = tap.tms ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: state_next = tap.tms ? ST_SEL_DR : ST_RTI;
            default: state_next = ST_TLR;
        endcase
    end

    // five clocks with the select high always reach reset
    always_ff @(posedge tck) begin
        if (tap_rst) begin
            state_reg <= ST_TLR;
        end else begin
            state_reg <= state_next;
        end
    end

    // strobes mean "this rising edge performs the action"
    assign tap.state = state_reg;
    assign tap.tlr = (state_reg == ST_TLR);
    assign tap.cap_dr = (state_reg == ST_CAP_DR);
    assign tap.sh_dr = (state_reg == ST_SH_DR);
    assign tap.upd_dr = (state_reg == ST_UPD_DR);
    assign tap.cap_ir = (state_reg == ST_CAP_IR);
    assign tap.sh_ir = (state_reg == ST_SH_IR);
    assign tap.upd_ir = (state_reg == ST_UPD_IR);

endmodule : bst_tap_fsm
`default_nettype wire

// ==== hdl/bst_tap_if.sv ====
// tap state and strobes passed from the controller to the scan logic
`timescale 1ns/1ps
`default_nettype none
interface bst_tap_if;
    import bst_pkg::*;
    logic tms;
    bst_tap_t state;
    logic tlr;
    logic cap_dr;
    logic sh_dr;
    logic upd_dr;
    logic cap_ir;
    logic sh_ir;
    logic upd_ir;
    modport fsm (input tms, output state, tlr, cap_dr, sh_dr, upd_dr, cap_ir, sh_ir, upd_ir);
    modport scan (output tms, input state, tlr, cap_dr, sh_dr, upd_dr, cap_ir, sh_ir, upd_ir);
endinterface : bst_tap_if
`default_nettype wire

// ==== hdl/bst_xfer.sv ====
// word crossing by toggle handshake; source holds data until the next load
`timescale 1ns/1ps
`default_nettype none
module bst_xfer #(
    parameter int W = 8,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // source side
    input wire logic src_clk,
    input wire logic src_rst,
    input wire logic src_load,
    input wire logic [W-1:0] src_data,
    // destination side
    input wire logic dst_clk,
    input wire logic dst_rst,
    output logic [W-1:0] dst_data,
    output logic dst_pulse
);

    logic tgl_reg;
    logic tgl_next;
    logic [W-1:0] hold_reg;
    logic [W-1:0] hold_next;
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic [W-1:0] dst_next;
    logic pulse_next;

    // source: hold the word and flip the toggle
    always_comb begin
        tgl_next = src_load ? ~tgl_reg : tgl_reg;
        hold_next = src_load ? src_data : hold_reg;
    end

    always_ff @(posedge src_clk) begin
        if (src_rst) begin
            tgl_reg <= 1'h0;
            hold_reg <= RST_VAL;
        end else begin
            tgl_reg <= tgl_next;
            hold_reg <= hold_next;
        end
    end

    // destination: loads must be spaced more than three destination clocks apart
    always_comb begin
        pulse_next = s2_reg ^ s3_reg;
        dst_next = pulse_next ? hold_reg : dst_data;
    end

    always_ff @(posedge dst_clk) begin
        s1_reg <= tgl_reg;
        s2_reg <= s1_reg;
        if (dst_rst) begin
            s3_reg <= s2_reg;
            dst_data <= RST_VAL;
            dst_pulse <= 1'h0;
        end else begin
            s3_reg <= s2_reg;
            dst_data <= dst_next;
            dst_pulse <= pulse_next;
        end
    end

endmodule : bst_xfer
`default_nettype wire

// ==== tb/bst_jtag_host.sv ====
// board-side scan controller model: makes tck, drives tms and tdi, reads tdo
`timescale 1ns/1ps
`default_nettype none
module bst_jtag_host (
    // link pins
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe
);
    // tck stands low between frames
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // one 32 ns period: bits launched after the fall, tdo taken at the rise
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #16;
        tck = 1'b1;
        q = tdo;
        #16;
        tck = 1'b0;
    endtask : step
    // tms high n times reaches test-logic-reset, then park in run-test/idle
    task automatic to_idle(input int n);
        logic b;
        #5.3;
        for (int i = 0; i < n; i++) step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
    endtask : to_idle
    // one scan from idle back to idle, lsb first; boundary tests only run
    // while no configuration load is in flight
    task automatic scan(input logic ir, input logic [63:0] d, input int n,
        output logic [63:0] q);
        logic b;
        q = '0;
        #5.3;
        step(1'b1, 1'b0, b);
        if (ir) step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
        step(1'b0, 1'b0, b);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, d[i], b);
            q[i] = b;
        end
        step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
        tdi = ~tdi;  // released data line must not keep its last bit
    endtask : scan
endmodule : bst_jtag_host
`default_nettype wire

// ==== tb/bst_port_checker.sv ====
// concurrent checks on the pins of the boundary-scan test port
`timescale 1ns/1ps
`default_nettype none
module bst_port_checker
    import bst_pkg::*;
#(
    parameter int PADS = 4
) (
    // clocks and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic tck,
    // scan link
    input wire logic tms,
    input wire logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe,
    // pads and configuration
    input wire logic [PADS-1:0] pad_in,
    input wire logic [PADS-1:0] core_in,
    input wire logic [PADS-1:0] pad_out,
    input wire logic [PADS-1:0] pad_oe,
    input wire logic [PADS*STD_W-1:0] pad_iostd,
    input wire logic [CFG_W-1:0] cfg_data,
    input wire logic cfg_valid
);
    // next tap state per state index, nibble n for state n
    localparam logic [63:0] NXT0 = 64'h1bdd_bba1_4664_4311;
    localparam logic [63:0] NXT1 = 64'h2fef_cc02_8785_5920;
    logic [3:0] st_reg, st_next;
    logic [IR_W-1:0] irs_reg, irs_next, ir_reg, ir_next;
    logic [2:0] cyc_reg, cyc_next;
    logic byp;
    // shadow tap state and instruction rebuilt from tms, tdi and sys_rst alone
    always_comb begin
        st_next = tms ? NXT1[4*st_reg+:4] : NXT0[4*st_reg+:4];
        irs_next = (st_reg == 4'hb) ? {tdi, irs_reg[IR_W-1:1]} : irs_reg;
        ir_next = (st_reg == 4'hf) ? irs_reg : ir_reg;
        if (st_reg == 4'ha) irs_next = 10'h001;
        if (sys_rst || st_reg == 4'h0) ir_next = IR_BYPASS;
        if (sys_rst) st_next = 4'h0;
    end
    always_ff @(posedge tck) begin
        st_reg <= st_next;
        irs_reg <= irs_next;
        ir_reg <= ir_next;
    end
    // core edges since reset, saturating; the pin path needs three to fill
    always_comb cyc_next = sys_rst ? 3'h0 : cyc_reg + {2'h0, cyc_reg != 3'h7};
    always_ff @(posedge core_clk) cyc_reg <= cyc_next;
    assign byp = !(ir_reg inside {IR_EXTEST, IR_SAMPLE, IR_CONFIG});

    AST_RESET_VALUES: assert property (@(posedge core_clk)
        sys_rst |=> {pad_out, pad_oe, pad_iostd, cfg_data, cfg_valid, core_in} == '0)
        else $error("pads or config not cleared by reset");
    AST_CFG_ONE_PULSE: assert property (@(posedge core_clk) disable iff (sys_rst)
        cfg_valid |=> !cfg_valid)
        else $error("config strobe longer than one cycle");
    AST_CFG_HOLD: assert property (@(posedge core_clk) disable iff (sys_rst)
        !cfg_valid |-> $stable(cfg_data))
        else $error("config byte changed without strobe");
    AST_CORE_IN_DELAY: assert property (@(posedge core_clk) disable iff (sys_rst)
        cyc_reg > 3'h3 |-> core_in == $past(pad_in, 3))
        else $error("pin level not passed to core in three cycles");
    AST_OE_IN_SHIFT: assert property (@(posedge tck) disable iff (sys_rst)
        tdo_oe == (st_reg == 4'h4 || st_reg == 4'hb))
        else $error("scan output enable outside shift states");
    AST_IR_CAPTURE: assert property (@(posedge tck) disable iff (sys_rst)
        st_reg == 4'ha ##1 st_reg == 4'hb |-> tdo)
        else $error("instruction capture bit 0 not one");
    AST_BYPASS_ZERO: assert property (@(posedge tck) disable iff (sys_rst)
        (st_reg == 4'h3 && byp) ##1 st_reg == 4'h4 |-> !tdo)
        else $error("bypass stage did not capture zero");
    AST_BYPASS_DELAY: assert property (@(posedge tck) disable iff (sys_rst)
        (st_reg == 4'h4 && byp) ##1 st_reg == 4'h4 |-> tdo == $past(tdi))
        else $error("bypass path not one stage");
endmodule : bst_port_checker
bind bst_port bst_port_checker #(.PADS(PADS)) chk_u (.core_clk(core_clk), .sys_rst(sys_rst),
    .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .pad_in(pad_in),
    .core_in(core_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_iostd(pad_iostd),
    .cfg_data(cfg_data), .cfg_valid(cfg_valid));
`default_nettype wire

// ==== tb/tb_bst_port.sv ====
// self-checking bench for the boundary-scan test port
`timescale 1ns/1ps
`default_nettype none
module tb_bst_port;
    import bst_pkg::*;
    localparam int PADS = 4;
    localparam logic [63:0] DPAT = 64'h00c3_a5f0_96e1;
    typedef struct {logic [IR_W-1:0] code; int dly;} bst_row_t;
    bst_row_t rows [6] = '{'{IR_EXTEST, 20}, '{IR_SAMPLE, 20}, '{IR_BYPASS, 1},
        '{10'h155, 1}, '{10'h001, 1}, '{10'h3fe, 1}};
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic tck, tms, tdi, tdo, tdo_oe, cfg_valid;
    logic [PADS-1:0] core_out = '0, core_oe = '0, pad_in = '0, core_in, pad_out, pad_oe;
    logic [PADS*STD_W-1:0] pad_iostd;
    logic [CFG_W-1:0] cfg_data;
    logic [63:0] q, e, g, pre = '0;
    int error_cnt = 0;
    int tests_run = 0;
    int cfg_cnt = 0;

    always #2 core_clk = ~core_clk;
    // count config strobes away from the edge that launches them
    always @(negedge core_clk) if (cfg_valid === 1'b1) cfg_cnt++;

    bst_port #(.PADS(PADS)) dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .tck(tck),
        .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .core_out(core_out),
        .core_oe(core_oe), .core_in(core_in), .pad_in(pad_in), .pad_out(pad_out),
        .pad_oe(pad_oe), .pad_iostd(pad_iostd), .cfg_data(cfg_data), .cfg_valid(cfg_valid));
    bst_jtag_host host_u (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic stop_test();
        $display("counts: %0d checks, %0d mismatches", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    // instruction load; capture always shifts out 0x001 first
    task automatic load(input logic [IR_W-1:0] code);
        logic [63:0] r;
        host_u.scan(1'b1, 64'(code), IR_W, r);
        chk("ir capture", 64'h1, 64'(r[IR_W-1:0]));
    endtask : load
    task automatic byp_chk();
        host_u.scan(1'b0, 64'hb38d, 16, q);
        chk("bypass one stage", 64'h671a, 64'(q[15:0]));
    endtask : byp_chk
    task automatic settle();
        repeat (2) @(negedge core_clk);
    endtask : settle
    // one field of every boundary cell, pad 0 in bit 0
    function automatic logic [PADS-1:0] field(input logic [63:0] v, input int b);
        for (int i = 0; i < PADS; i++) field[i] = v[5*i+b];
    endfunction : field

    initial begin
        host_u.to_idle(6);
        @(negedge core_clk);
        sys_rst = 1'b0;
        host_u.to_idle(4);
        // each code in rows, all but config, then a scan longer than the chain shows its length
        foreach (rows[i]) begin
            load(rows[i].code);
            host_u.scan(1'b0, DPAT, 40, q);
            e = DPAT & ((64'h1 << (40 - rows[i].dly)) - 64'h1);
            g = 64'(q[39:0]) >> rows[i].dly;
            chk("dr path", e, g);
            if (rows[i].dly == 1) chk("bypass capture", 64'h0, 64'(q[0]));
            $display("done: code %h", rows[i].code);
        end
        // preload under sample: pins stay with the core, io standard follows
        for (int i = 0; i < PADS; i++) pre[5*i+:5] = {2'(i), 1'b1, ~i[0], 1'b0};
        @(negedge core_clk);
        pad_in = 4'ha;
        core_out = 4'h6;
        core_oe = 4'h9;
        load(IR_SAMPLE);
        host_u.scan(1'b0, pre, 20, q);
        settle();
        chk("sample in", 64'ha, 64'(field(q, 0)));
        chk("sample out", 64'h6, 64'(field(q, 1)));
        chk("sample oe", 64'h9, 64'(field(q, 2)));
        chk("core in", 64'ha, 64'(core_in));
        chk("pins in sample", 64'h96, 64'({pad_oe, pad_out}));
        chk("io standard", 64'he4, 64'(pad_iostd));
        $display("done: sample and preload");
        // extest drives the preloaded word and captures the inputs
        load(IR_EXTEST);
        settle();
        chk("extest pins", 64'hf5, 64'({pad_oe, pad_out}));
        pad_in = 4'h3;
        host_u.scan(1'b0, pre ^ 64'hc6318, 20, q);
        settle();
        chk("extest in", 64'h3, 64'(field(q, 0)));
        chk("extest out", 64'h5, 64'(field(q, 1)));
        chk("io standard", 64'h1b, 64'(pad_iostd));
        host_u.to_idle(5);
        byp_chk();
        $display("done: extest and tms reset");
        // config bytes; a partial byte is dropped at the next capture
        load(IR_CONFIG);
        host_u.scan(1'b0, 64'h3c96, 16, q);
        settle();
        chk("config byte", 64'h3c, 64'(cfg_data));
        host_u.scan(1'b0, 64'h5e1, 12, q);
        host_u.scan(1'b0, 64'h7b, 8, q);
        for (int k = 0; k < 40 && cfg_cnt < 4; k++) @(negedge core_clk);
        if (cfg_cnt < 4) begin
            error_cnt++;
            $display("CHECK FAILED config wait expected 4 seen %0d", cfg_cnt);
        end
        chk("config count", 64'h4, 64'(cfg_cnt));
        chk("config byte", 64'h7b, 64'(cfg_data));
        $display("done: configuration");
        // reset in mid-run clears pads and config and reloads bypass
        @(negedge core_clk);
        sys_rst = 1'b1;
        host_u.to_idle(3);
        settle();
        g = 64'({pad_out, pad_oe, pad_iostd, cfg_data, cfg_valid});
        chk("reset values", 64'h0, g);
        sys_rst = 1'b0;
        host_u.to_idle(4);
        byp_chk();
        $display("done: mid-run reset");
        stop_test();
    end
endmodule : tb_bst_port
`default_nettype wire
